// File: logic/giq_pkg.sv
package giq_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_QSEL_LO = 8'h00;
  localparam logic [7:0] ADDR_QSEL_HI = 8'h04;
  localparam logic [7:0] ADDR_PRD = 8'h08;
  localparam logic [7:0] ADDR_ROUTE = 8'h0c;
  localparam logic [7:0] ADDR_QUAL = 8'h10;
  localparam logic [7:0] ADDR_RAW = 8'h14;
  localparam logic [7:0] ADDR_ROUTE_EN = 8'h18;
  localparam logic [7:0] ADDR_DEFAULT = 8'h1c;
  localparam int PRD_W = 8;
  localparam int PRD_GRP = 8;
  localparam int ROUTE_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // qualification codes
  // ****************************************
  typedef enum logic [1:0] {
    GIQ_SYNC = 2'h0,
    GIQ_WIN3 = 2'h1,
    GIQ_WIN6 = 2'h2,
    GIQ_ASYNC = 2'h3
  } giq_qsel_t;
  localparam logic [31:0] QSEL_RESET = 32'h0000_0000;
  localparam logic [31:0] PRD_RESET = 32'h0000_0000;
  localparam int WIN3 = 3;
  localparam int WIN6 = 6;
endpackage

// File: logic/giq_pin_if.sv
`timescale 1ns/10ps
`default_nettype none
// per-group carrier between the top and the qualifier slices
interface giq_pin_if #(parameter int N = 8);
  logic [N-1:0] pin;
  logic [2*N-1:0] qsel;
  logic tick;
  logic [N-1:0] qual;
  modport top (output pin, output qsel, output tick, input qual);
  modport slice (input pin, input qsel, input tick, output qual);
endinterface
`default_nettype wire

// File: logic/giq_group.sv
`timescale 1ns/10ps
`default_nettype none
// eight pins sharing one sample tick
module giq_group #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // pins
  giq_pin_if.slice pif
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0][5:0] win;
    logic [N-1:0] q;
  } giq_grp_t;
  giq_grp_t st, next_st;
  logic [N-1:0] outv;

  always_comb begin
    next_st = st;
    next_st.s1 = pif.pin;
    next_st.s2 = st.s1;
    for (int i = 0; i < N; i++) begin
      if (pif.tick) begin
        next_st.win[i] = {st.win[i][4:0], st.s2[i]};
      end
      case (giq_pkg::giq_qsel_t'(pif.qsel[2*i +: 2]))
        giq_pkg::GIQ_SYNC: next_st.q[i] = st.s2[i];
        giq_pkg::GIQ_WIN3: begin
          if (&st.win[i][2:0]) next_st.q[i] = 1'b1;
          else if (~|st.win[i][2:0]) next_st.q[i] = 1'b0;
        end
        giq_pkg::GIQ_WIN6: begin
          if (&st.win[i]) next_st.q[i] = 1'b1;
          else if (~|st.win[i]) next_st.q[i] = 1'b0;
        end
        default: next_st.q[i] = st.q[i];
      endcase
      // async mode bypasses the synchroniser and qualifier flops so the peripheral can synchronise itself; the top still registers qual and per once
      outv[i] = (pif.qsel[2*i +: 2] == 2'h3) ? pif.pin[i] : st.q[i];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pif.qual = outv;
endmodule // giq_group
`default_nettype wire

// File: logic/giq_top.sv
`timescale 1ns/10ps
`default_nettype none
module giq_top #(
  parameter int NPIN = 32,
  parameter int NPER = 4,
  parameter logic [31:0] PER_DEFAULT = 32'h0000_0000
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // pins and peripheral inputs
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] qual_o,
  output logic [NPER-1:0] per_in_o,
  // axi4-lite write
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i
);
  localparam int NGRP = NPIN / giq_pkg::PRD_GRP;
  // one bit wider than the period field so a reload of 2*p-1 never wraps
  localparam int CNT_W = giq_pkg::PRD_W + 1;
  localparam int ROUTE_BITS = NPER * giq_pkg::ROUTE_W;

  typedef struct packed {
    logic [2*NPIN-1:0] qsel;
    logic [NGRP-1:0][giq_pkg::PRD_W-1:0] prd;
    logic [NGRP-1:0][CNT_W-1:0] cnt;
    logic [NGRP-1:0] tick;
    logic [NPER-1:0][giq_pkg::ROUTE_W-1:0] route;
    logic [NPER-1:0] route_en;
    logic [NPIN-1:0] qual;
    logic [NPER-1:0] per;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // registered ready copies so every bus port leaves a flop
    logic awready;
    logic wready;
    logic arready;
  } giq_top_t;
  giq_top_t st, next_st;
  logic [NPIN-1:0] qual_w;

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  // ****************************************
  // qualifier groups
  // ****************************************
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    giq_pin_if #(.N(giq_pkg::PRD_GRP)) pif ();
    assign pif.pin = pin_i[g*giq_pkg::PRD_GRP +: giq_pkg::PRD_GRP];
    assign pif.qsel = st.qsel[2*g*giq_pkg::PRD_GRP +: 2*giq_pkg::PRD_GRP];
    assign pif.tick = st.tick[g];
    assign qual_w[g*giq_pkg::PRD_GRP +: giq_pkg::PRD_GRP] = pif.qual;
    giq_group #(.N(giq_pkg::PRD_GRP)) u_grp (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .pif(pif)
    );
  end

  always_comb begin
    logic [31:0] rd;
    logic ok;
    rd = '0;
    ok = 1'b1;
    next_st = st;
    // ****************************************
    // sample period dividers
    // ****************************************
    for (int g = 0; g < NGRP; g++) begin
      // period 0 samples every cycle, period p every 2*p cycles
      if (st.cnt[g] == '0) begin
        next_st.tick[g] = 1'b1;
        next_st.cnt[g] = (st.prd[g] == '0) ? '0 : CNT_W'(2 * st.prd[g] - 1);
      end else begin
        next_st.tick[g] = 1'b0;
        next_st.cnt[g] = st.cnt[g] - 1'b1;
      end
    end
    // ****************************************
    // outputs and peripheral routing
    // ****************************************
    next_st.qual = qual_w;
    for (int p = 0; p < NPER; p++) begin
      // several peripherals may name the same pin as their route source
      if (st.route_en[p]) next_st.per[p] = qual_w[st.route[p]];
      else next_st.per[p] = PER_DEFAULT[p];
    end
    // ****************************************
    // axi4-lite write
    // ****************************************
    if (s_awvalid_i && !st.aw_got) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_awaddr_i;
    end
    if (s_wvalid_i && !st.w_got) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_wdata_i;
      next_st.wstrb = s_wstrb_i;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = giq_pkg::RESP_OKAY;
      case (st.awaddr)
        giq_pkg::ADDR_QSEL_LO: next_st.qsel[31:0] = wmerge(st.qsel[31:0], st.wdata, st.wstrb);
        giq_pkg::ADDR_QSEL_HI: next_st.qsel[63:32] = wmerge(st.qsel[63:32], st.wdata, st.wstrb);
        giq_pkg::ADDR_PRD: next_st.prd = wmerge(st.prd, st.wdata, st.wstrb);
        giq_pkg::ADDR_ROUTE: next_st.route =
            ROUTE_BITS'(wmerge(32'(st.route), st.wdata, st.wstrb));
        giq_pkg::ADDR_ROUTE_EN: next_st.route_en =
            NPER'(wmerge(32'(st.route_en), st.wdata, st.wstrb));
        // read-only and unmapped offsets answer an error and change nothing
        default: next_st.bresp = giq_pkg::RESP_SLVERR;
      endcase
    end
    if (st.bvalid && s_bready_i) next_st.bvalid = 1'b0;
    // ****************************************
    // axi4-lite read
    // ****************************************
    case (s_araddr_i)
      giq_pkg::ADDR_QSEL_LO: rd = st.qsel[31:0];
      giq_pkg::ADDR_QSEL_HI: rd = st.qsel[63:32];
      giq_pkg::ADDR_PRD: rd = st.prd;
      giq_pkg::ADDR_ROUTE: rd = 32'(st.route);
      giq_pkg::ADDR_QUAL: rd = st.qual;
      giq_pkg::ADDR_RAW: rd = pin_i;
      giq_pkg::ADDR_ROUTE_EN: rd = 32'(st.route_en);
      giq_pkg::ADDR_DEFAULT: rd = 32'(PER_DEFAULT[NPER-1:0]);
      default: ok = 1'b0;
    endcase
    if (s_arvalid_i && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd;
      next_st.rresp = ok ? giq_pkg::RESP_OKAY : giq_pkg::RESP_SLVERR;
    end else if (st.rvalid && s_rready_i) begin
      next_st.rvalid = 1'b0;
    end

    // ****************************************
    // ready flags
    // ****************************************
    // taken from the next holding flags so ready drops on the edge that takes a request
    next_st.awready = !next_st.aw_got;
    next_st.wready = !next_st.w_got;
    next_st.arready = !next_st.rvalid;
  end

  // ****************************************
  // state register
  // ****************************************

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0; // qsel resets to synchronise-only
      // the bus is ready to take a request as soon as reset lets go
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign qual_o = st.qual;
  assign per_in_o = st.per;
  // ****************************************
  // ports
  // ****************************************
  assign s_awready_o = st.awready;
  assign s_wready_o = st.wready;
  assign s_bvalid_o = st.bvalid;
  assign s_bresp_o = st.bresp;
  assign s_arready_o = st.arready;
  assign s_rvalid_o = st.rvalid;
  assign s_rdata_o = st.rdata;
  assign s_rresp_o = st.rresp;
endmodule // giq_top
`default_nettype wire

// File: bench/giq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module giq_asserts #(
  parameter int NPIN = 32,
  parameter int NPER = 4
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic [NPIN-1:0] qual_o,
  input wire logic [NPER-1:0] per_in_o,
  input wire logic s_awvalid_i,
  input wire logic s_awready_o,
  input wire logic s_wvalid_i,
  input wire logic s_wready_o,
  input wire logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i
);
  // ****************************************
  // reset state and bus handshakes
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; disable iff (1'b0) rst_i |=> qual_o == '0 && per_in_o == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear in reset");
  property p_arblk; s_rvalid_o |-> !s_arready_o; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while answering");
  property p_rans; s_arvalid_i && s_arready_o |=> s_rvalid_o; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bans; s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o |-> ##2 s_bvalid_o; endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_awblk; s_awvalid_i && s_awready_o |=> !s_awready_o; endproperty
  a_awblk: assert property (p_awblk) else $error("address taken twice");
  property p_wblk; s_wvalid_i && s_wready_o |=> !s_wready_o; endproperty
  a_wblk: assert property (p_wblk) else $error("data taken twice");
  property p_bclr; s_bvalid_o && s_bready_i |=> !s_bvalid_o; endproperty
  a_bclr: assert property (p_bclr) else $error("write answer repeated");
  property p_rclr; s_rvalid_o && s_rready_i |=> !s_rvalid_o; endproperty
  a_rclr: assert property (p_rclr) else $error("read answer repeated");
endmodule // giq_asserts
bind giq_top giq_asserts #(.NPIN(NPIN), .NPER(NPER)) i_giq_asserts (.*);
`default_nettype wire

// File: bench/giq_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// external drivers: a pin only moves just after a clock edge
module giq_pin_model (
  // clock
  input wire logic core_clk_i,
  // levels and pins
  input wire logic [31:0] lvl_i,
  output logic [31:0] pin_o
);
  initial pin_o = 32'h0;
  always @(posedge core_clk_i) pin_o <= lvl_i;
endmodule // giq_pin_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [1:0] OK = giq_pkg::RESP_OKAY;
  localparam logic [31:0] DEF = 32'h0000_000a;
  // group one ticks every 4 cycles (period 2)
  localparam int T1 = 4;
  logic core_clk_i, rst_i, s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o;
  logic s_bvalid_o, s_bready_i, s_arvalid_i, s_arready_o, s_rvalid_o, s_rready_i;
  logic [31:0] lvl, pin_i, qual_o, seen, s_wdata_i, s_rdata_o, lf;
  logic [3:0] per_in_o, s_wstrb_i;
  logic [7:0] s_awaddr_i, s_araddr_i;
  logic [1:0] s_bresp_o, s_rresp_o;
  logic [33:0] qr[$];
  logic [1:0] qb[$];
  int n_errors, tests_run;
  int pw[5] = '{2, 3, 5, 6, 14};
  giq_pin_model i_giq_pin_model (.core_clk_i(core_clk_i), .lvl_i(lvl), .pin_o(pin_i));
  giq_top #(.PER_DEFAULT(DEF)) i_giq_top (.*);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    qb.push_back(e);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_awready_o === 1'b1) s_awvalid_i <= 1'b0;
      if (s_wready_o === 1'b1) s_wvalid_i <= 1'b0;
    end while (s_bvalid_o !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    qr.push_back(e);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_arready_o === 1'b1) s_arvalid_i <= 1'b0;
    end while (s_rvalid_o !== 1'b1);
  endtask
  // gathers every qualified level seen over n cycles
  task automatic acc(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      seen = seen | qual_o;
    end
  endtask
  always @(posedge core_clk_i) begin
    if (s_bvalid_o === 1'b1 && s_bready_i) chk("bresp", s_bresp_o, qb.pop_front());
    if (s_rvalid_o === 1'b1 && s_rready_i) chk("read", {s_rresp_o, s_rdata_o}, qr.pop_front());
  end
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100us;
    n_errors++;
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_i, s_bready_i, s_rready_i, s_wstrb_i} = 7'h7f;
    {s_awvalid_i, s_wvalid_i, s_arvalid_i, s_awaddr_i, s_araddr_i} = 19'h0;
    {lvl, s_wdata_i, seen, n_errors, tests_run} = '0;
    lf = 32'h0000_0033;
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(giq_pkg::ADDR_QSEL_LO, {OK, giq_pkg::QSEL_RESET});
    rd(giq_pkg::ADDR_QSEL_HI, {OK, giq_pkg::QSEL_RESET});
    rd(giq_pkg::ADDR_PRD, {OK, giq_pkg::PRD_RESET});
    rd(giq_pkg::ADDR_DEFAULT, {OK, DEF});
    rd(8'h40, {giq_pkg::RESP_SLVERR, 32'h0});
    wr(giq_pkg::ADDR_QUAL, 32'h1, giq_pkg::RESP_SLVERR);
    for (int i = 0; i < 3; i++) begin
      lf = lfsr(lf);
      lvl <= lf;
      repeat (6) @(posedge core_clk_i);
      chk("qual sync", qual_o, lf);
      rd(giq_pkg::ADDR_RAW, {OK, lf});
    end
    wr(giq_pkg::ADDR_QSEL_LO, 32'hffff_ffff, OK);
    wr(giq_pkg::ADDR_QSEL_HI, 32'hffff_ffff, OK);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      lvl <= lf;
      repeat (3) @(posedge core_clk_i);
      chk("qual async", qual_o, lf);
      wr(giq_pkg::ADDR_ROUTE, {12'h0, lf[19:0]}, OK);
      wr(giq_pkg::ADDR_ROUTE_EN, {28'h0, lf[23:20]}, OK);
      repeat (4) @(posedge core_clk_i);
      for (int k = 0; k < 4; k++) chk("per", per_in_o[k], lf[20+k] ? lf[lf[5*k +: 5]] : DEF[k]);
    end
    lvl <= 32'h0;
    wr(giq_pkg::ADDR_QSEL_LO, 32'h5555_5555, OK);
    wr(giq_pkg::ADDR_QSEL_HI, 32'haaaa_aaaa, OK);
    wr(giq_pkg::ADDR_PRD, 32'h0000_0200, OK);
    rd(giq_pkg::ADDR_PRD, {OK, 32'h0000_0200});
    acc(40);
    foreach (pw[j]) begin
      seen = 32'h0;
      lvl <= 32'hffff_ffff;
      acc(pw[j]);
      lvl <= 32'h0;
      acc(40);
      chk("seen", seen, {{16{pw[j] >= giq_pkg::WIN6}}, {8{pw[j] >= giq_pkg::WIN3 * T1 + 2}}, {8{pw[j] >= giq_pkg::WIN3}}});
    end
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
